// >>> rsc_pkg.sv
package rsc_pkg;
  // command opcodes
  localparam logic [7:0] CMD_RD_REG_MASK = 8'he0;
  localparam logic [7:0] CMD_RD_REG      = 8'h00;
  localparam logic [7:0] CMD_WR_REG      = 8'h20;
  localparam logic [7:0] CMD_RX_READ     = 8'h61;
  localparam logic [7:0] CMD_TX_WRITE    = 8'ha0;
  localparam logic [7:0] CMD_TX_FLUSH    = 8'he1;
  localparam logic [7:0] CMD_RX_FLUSH    = 8'he2;
  localparam logic [7:0] CMD_REPEAT      = 8'he3;
  localparam logic [7:0] CMD_UNLOCK      = 8'h50;
  localparam logic [7:0] CMD_RX_WIDTH    = 8'h60;
  localparam logic [7:0] CMD_ACK_WR_BASE = 8'ha8;
  localparam logic [7:0] CMD_ACK_WR_MASK = 8'hf8;
  localparam logic [7:0] CMD_NOACK_WR    = 8'hb0;
  localparam logic [7:0] CMD_IDLE        = 8'hff;
  localparam logic [7:0] UNLOCK_KEY      = 8'h73;
  localparam logic [2:0] PIPE_MAX        = 3'h5;
  localparam logic [2:0] PIPE_EMPTY      = 3'h7;
  // register addresses and fields
  localparam logic [4:0] REG_CONFIG      = 5'h00;
  localparam logic [4:0] REG_STATUS      = 5'h07;
  localparam logic [4:0] REG_FIFO_STATUS = 5'h17;
  localparam logic [4:0] REG_TEST_LO     = 5'h18;
  localparam logic [4:0] REG_TEST_HI     = 5'h1b;
  localparam int         BIT_DATA_RECEIVED_FLAG       = 6;
  localparam int         BIT_DATA_SENT_FLAG       = 5;
  localparam int         BIT_RETRY_LIMIT_FLAG      = 4;
  localparam logic [7:0] CONFIG_RST      = 8'h08;
  localparam int         REG_BYTES       = 5;
  localparam int         NREG            = 32;
  // fifo geometry
  localparam int         FIFO_DEPTH      = 3;
  localparam int         PAYLOAD_BYTES   = 32;
endpackage : rsc_pkg

// >>> rsc_spi_core.sv
`timescale 1ns/1ps
// How it works
// - read opcode returns register bytes, LSByte first
// - register writes only in power down/standby
// - rx read from byte 0, entry then popped
// - tx write fills new entry from byte 0
// - tx flush empties transmit fifo
// - repeat flag held until tx write or flush
// - unlock with key 0x73 toggles optional features
// - locked features ignore writes, read zeros
// - width read returns head rx payload size
// - ack payload write carries pipe 0..5
// - no-ack write marks single packet no-ack
// - idle opcode does nothing but shift status
// - multi-byte registers LSByte first, partial keeps
// - status byte shifted out after select falls
// - pipe number updates as interrupt pin falls
// - three-entry 32-byte tx and rx fifos
// - blocked ack fifo released by tx flush
// - retry limit keeps failed payload in fifo
// - irq low while any enabled flag set
// - mask bits block sources; unmasked at reset
// - undefined bits zero; test addresses protected
// - command msb first, data LSByte first
// - status flag bits 6,5,4, write one clears
// - config mask bits 6,5,4
module rsc_spi_core
  import rsc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       ce,
  input  wire logic       spi_sck,
  input  wire logic       spi_cs_n,
  input  wire logic       spi_mosi,
  output logic            spi_miso,
  output logic            spi_miso_oe,
  output logic            irq_n,
  input  wire logic       standby,
  input  wire logic       receiver_role,
  input  wire logic       ev_received,
  input  wire logic [2:0] ev_pipe,
  input  wire logic [7:0] ev_rx_byte,
  input  wire logic       ev_rx_byte_valid,
  input  wire logic       ev_rx_commit,
  input  wire logic       ev_sent,
  input  wire logic       ev_retry_limit,
  input  wire logic       ev_tx_done,
  input  wire logic       link_lost_all,
  output logic            tx_payload_ready,
  output logic            tx_no_ack,
  output logic            tx_repeat,
  output logic            tx_blocked,
  output logic            features_on
);

  typedef enum logic [3:0] {
    ST_CMD  = 4'b0001,
    ST_DATA = 4'b0010,
    ST_DONE = 4'b0100,
    ST_IDLE = 4'b1000
  } rsc_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [2:0] sck_s, cs_s, mosi_s;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sck_s  <= 3'h0;
      cs_s   <= 3'h7;
      mosi_s <= 3'h0;
    end else if (ce) begin
      sck_s  <= {sck_s[1:0], spi_sck};
      cs_s   <= {cs_s[1:0], spi_cs_n};
      mosi_s <= {mosi_s[1:0], spi_mosi};
    end
  end
  // only stages 1 and 2 feed logic; stage 0 is the metastability catcher
  wire sck_rise = sck_s[1] & ~sck_s[2];
  wire sck_fall = ~sck_s[1] & sck_s[2];
  wire cs_fall  = ~cs_s[1] & cs_s[2];
  wire cs_rise  = cs_s[1] & ~cs_s[2];
  wire sel      = ~cs_s[1];
  wire din      = mosi_s[2];

  ////////////////////////////////////////////////////////////////////////////
  // storage
  logic [7:0] regs [NREG][REG_BYTES];
  logic [7:0] txm [FIFO_DEPTH][PAYLOAD_BYTES];
  logic [7:0] rxm [FIFO_DEPTH][PAYLOAD_BYTES];
  logic [5:0] rx_len [FIFO_DEPTH];
  logic [2:0] rx_pipe [FIFO_DEPTH];
  logic [1:0] tx_wp, tx_rp, tx_cnt, rx_wp, rx_rp, rx_cnt;
  logic [5:0] rx_fill;
  logic [2:0] flags;  // data_received_flag, data_sent_flag, retry_limit_flag
  logic [2:0] pipe_number;
  logic       unlocked;
  logic       repeat_on;
  logic       noack_pend;

  ////////////////////////////////////////////////////////////////////////////
  // serial shifter
  rsc_state_t state;
  logic [7:0] cmd, sh_in, sh_out;
  logic [2:0] bitn;
  logic [5:0] byten;
  logic       byte_done;
  logic [7:0] rx_byte;
  logic       tx_full, rx_empty;
  assign tx_full  = (tx_cnt == 2'(FIFO_DEPTH));
  assign rx_empty = (rx_cnt == 2'h0);
  wire [7:0] status = {1'b0, flags, pipe_number, tx_full};

  wire is_wrreg = (cmd & CMD_RD_REG_MASK) == CMD_WR_REG;
  wire is_ackwr = (cmd & CMD_ACK_WR_MASK) == CMD_ACK_WR_BASE;
  wire is_txwr  = (cmd == CMD_TX_WRITE) | (unlocked & (cmd == CMD_NOACK_WR)) |
                  (unlocked & is_ackwr & (cmd[2:0] <= PIPE_MAX));
  wire quiet    = standby;  // power down or standby
  wire [4:0] ra = cmd[4:0];

  // read data for the byte about to be shifted out
  function automatic logic [7:0] rd_byte(input logic [7:0] c,
                                         input logic [5:0] n);
    logic [7:0] v;
    v = 8'h00;
    if ((c & CMD_RD_REG_MASK) == CMD_RD_REG) begin
      if (c[4:0] == REG_STATUS && n == 6'h0)
        v = status;
      else if (c[4:0] == REG_FIFO_STATUS && n == 6'h0)
        v = {1'b0, repeat_on, tx_full, tx_cnt == 2'h0, 2'b00,
             rx_cnt == 2'(FIFO_DEPTH), rx_empty};
      else if (n < 6'(REG_BYTES))
        v = regs[c[4:0]][n[2:0]];
    end else if (c == CMD_RX_READ && !rx_empty)
      v = rxm[rx_rp][n[4:0]];
    else if (c == CMD_RX_WIDTH && unlocked && n == 6'h0 && !rx_empty)
      v = {2'b00, rx_len[rx_rp]};
    return v;
  endfunction

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state     <= ST_IDLE;
      bitn      <= 3'h0;
      byten     <= 6'h0;
      cmd       <= CMD_IDLE;
      sh_in     <= 8'h00;
      sh_out    <= 8'h00;
      byte_done <= 1'b0;
      rx_byte   <= 8'h00;
    end else if (ce) begin
      byte_done <= 1'b0;
      if (cs_rise || !sel) begin
        state <= ST_IDLE;
        bitn  <= 3'h0;
      end else if (cs_fall) begin
        state  <= ST_CMD;
        bitn   <= 3'h0;
        byten  <= 6'h0;
        sh_out <= status;
      end else if (sck_rise && state != ST_IDLE) begin
        sh_in <= {sh_in[6:0], din};
        bitn  <= bitn + 3'h1;
        if (bitn == 3'h7) begin
          byte_done <= 1'b1;
          rx_byte   <= {sh_in[6:0], din};
          if (state == ST_CMD) begin
            cmd   <= {sh_in[6:0], din};
            state <= ST_DATA;
          end else
            byten <= byten + 6'h1;
        end
      end else if (sck_fall && state != ST_IDLE) begin
        if (bitn == 3'h0 && state == ST_DATA)
          sh_out <= rd_byte(cmd, byten);
        else
          sh_out <= {sh_out[6:0], 1'b0};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command execution on completed bytes
  wire first_cmd = byte_done && state == ST_DATA && bitn == 3'h0 &&
                   byten == 6'h0;
  wire data_byte = byte_done && byten != 6'h0;
  wire [5:0] didx = byten - 6'h1;
  logic       tx_open;   // current write accepted into fifo
  logic [5:0] tx_bytes;
  wire tx_flush = first_cmd && rx_byte == CMD_TX_FLUSH;
  wire rx_flush = first_cmd && rx_byte == CMD_RX_FLUSH;
  wire tx_commit = tx_open && cs_rise && tx_bytes != 6'h0;
  wire rx_pop = cs_rise && state == ST_DATA && cmd == CMD_RX_READ &&
                byten != 6'h0 && !rx_empty;
  wire unlock_hit = data_byte && didx == 6'h0 && cmd == CMD_UNLOCK &&
                    rx_byte == UNLOCK_KEY && quiet;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      tx_open    <= 1'b0;
      tx_bytes   <= 6'h0;
      noack_pend <= 1'b0;
    end else if (ce) begin
      if (cs_rise)
        tx_open <= 1'b0;
      else if (first_cmd) begin
        tx_open  <= 1'b0;
        tx_bytes <= 6'h0;
        // cmd was loaded on the same edge as rx_byte, so both agree here
        if (is_txwr && !tx_full)
          tx_open <= 1'b1;
        noack_pend <= unlocked && rx_byte == CMD_NOACK_WR;
      end else if (data_byte && tx_open && didx < 6'(PAYLOAD_BYTES)) begin
        txm[tx_wp][didx[4:0]] <= rx_byte;
        tx_bytes <= byten;
      end
    end
  end

  // register writes, byte by byte, upper bytes kept on a short write
  always_ff @(posedge clk) begin
    if (!nrst) begin
      for (int r = 0; r < NREG; r++)
        for (int b = 0; b < REG_BYTES; b++)
          regs[r][b] <= (r == 0 && b == 0) ? CONFIG_RST : 8'h00;
    end else if (ce) begin
      if (data_byte && is_wrreg && quiet && didx < 6'(REG_BYTES) &&
          !(ra >= REG_TEST_LO && ra <= REG_TEST_HI) &&
          ra != REG_STATUS && ra != REG_FIFO_STATUS)
        regs[ra][didx[2:0]] <= rx_byte;
    end
  end

  // unlock toggle and repeat flag
  always_ff @(posedge clk) begin
    if (!nrst) begin
      unlocked  <= 1'b0;
      repeat_on <= 1'b0;
    end else if (ce) begin
      if (unlock_hit)
        unlocked <= ~unlocked;
      if (tx_flush || (first_cmd && rx_byte == CMD_TX_WRITE))
        repeat_on <= 1'b0;
      else if (first_cmd && rx_byte == CMD_REPEAT)
        repeat_on <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fifo pointers
  wire tx_pop = ev_tx_done && tx_cnt != 2'h0 && !repeat_on;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      tx_wp  <= 2'h0;
      tx_rp  <= 2'h0;
      tx_cnt <= 2'h0;
    end else if (ce) begin
      if (tx_flush) begin
        tx_wp  <= 2'h0;
        tx_rp  <= 2'h0;
        tx_cnt <= 2'h0;
      end else begin
        if (tx_commit)
          tx_wp <= (tx_wp == 2'(FIFO_DEPTH - 1)) ? 2'h0 : tx_wp + 2'h1;
        if (tx_pop)
          tx_rp <= (tx_rp == 2'(FIFO_DEPTH - 1)) ? 2'h0 : tx_rp + 2'h1;
        tx_cnt <= tx_cnt + 2'(tx_commit) - 2'(tx_pop);
      end
    end
  end

  wire rx_push = ev_rx_commit && rx_cnt != 2'(FIFO_DEPTH) && rx_fill != 6'h0;
  wire [1:0] next_rx_rp = (rx_rp == 2'(FIFO_DEPTH - 1)) ? 2'h0 : rx_rp + 2'h1;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rx_wp   <= 2'h0;
      rx_rp   <= 2'h0;
      rx_cnt  <= 2'h0;
      rx_fill <= 6'h0;
    end else if (ce) begin
      if (ev_rx_byte_valid && rx_fill < 6'(PAYLOAD_BYTES) &&
          rx_cnt != 2'(FIFO_DEPTH)) begin
        rxm[rx_wp][rx_fill[4:0]] <= ev_rx_byte;
        rx_fill <= rx_fill + 6'h1;
      end
      if (rx_push) begin
        rx_len[rx_wp]  <= rx_fill;
        rx_pipe[rx_wp] <= ev_pipe;
        rx_fill        <= 6'h0;
      end
      if (rx_flush) begin
        rx_wp  <= 2'h0;
        rx_rp  <= 2'h0;
        rx_cnt <= 2'h0;
      end else begin
        if (rx_push)
          rx_wp <= (rx_wp == 2'(FIFO_DEPTH - 1)) ? 2'h0 : rx_wp + 2'h1;
        if (rx_pop)
          rx_rp <= next_rx_rp;
        rx_cnt <= rx_cnt + 2'(rx_push) - 2'(rx_pop);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky flags: hardware set beats write-one clear
  wire clr_wr = data_byte && is_wrreg && quiet && ra == REG_STATUS &&
                didx == 6'h0;
  wire [2:0] ev_set = {ev_received, ev_sent, ev_retry_limit};
  wire [2:0] ev_clr = clr_wr ? rx_byte[BIT_DATA_RECEIVED_FLAG:BIT_RETRY_LIMIT_FLAG] : 3'h0;
  always_ff @(posedge clk) begin
    if (!nrst)
      flags <= 3'h0;
    else if (ce)
      flags <= ev_set | (flags & ~ev_clr);
  end

  // pipe number moves together with the pin falling
  wire [7:0] cfg = regs[REG_CONFIG][0];
  wire [2:0] enabled = flags & ~cfg[BIT_DATA_RECEIVED_FLAG:BIT_RETRY_LIMIT_FLAG];
  wire [2:0] next_enabled = (ev_set | (flags & ~ev_clr)) &
                            ~cfg[BIT_DATA_RECEIVED_FLAG:BIT_RETRY_LIMIT_FLAG];
  always_ff @(posedge clk) begin
    if (!nrst)
      pipe_number <= PIPE_EMPTY;
    else if (ce) begin
      if ((rx_empty || (rx_pop && rx_cnt == 2'h1)) && !rx_push)
        pipe_number <= PIPE_EMPTY;
      else if (rx_empty || (rx_pop && rx_cnt == 2'h1))
        pipe_number <= ev_pipe;  // new head slot is written this very cycle
      else if ((next_enabled != 3'h0 && enabled == 3'h0) || rx_pop ||
               pipe_number == PIPE_EMPTY)
        pipe_number <= rx_pipe[rx_pop ? next_rx_rp : rx_rp];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs
  always_ff @(posedge clk) begin
    if (!nrst) begin
      spi_miso         <= 1'b0;
      spi_miso_oe      <= 1'b0;
      irq_n            <= 1'b1;
      tx_payload_ready <= 1'b0;
      tx_no_ack        <= 1'b0;
      tx_repeat        <= 1'b0;
      tx_blocked       <= 1'b0;
      features_on      <= 1'b0;
    end else if (ce) begin
      spi_miso         <= sh_out[7];
      spi_miso_oe      <= sel && state != ST_IDLE;
      irq_n            <= ~(next_enabled != 3'h0);
      tx_payload_ready <= tx_cnt != 2'h0;
      if (tx_commit)
        tx_no_ack <= noack_pend;
      else if (tx_pop || tx_flush)
        tx_no_ack <= 1'b0;
      tx_repeat        <= repeat_on && receiver_role == 1'b0;
      tx_blocked       <= receiver_role && link_lost_all && tx_cnt != 2'h0;
      features_on      <= unlocked;
    end
  end

endmodule : rsc_spi_core

// >>> rsc_spi_core_monitor.sv
`timescale 1ns/1ps
module rsc_spi_core_monitor (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic spi_cs_n,
  input wire logic spi_miso_oe,
  input wire logic irq_n,
  input wire logic receiver_role,
  input wire logic ev_received,
  input wire logic ev_sent,
  input wire logic ev_retry_limit,
  input wire logic ev_tx_done,
  input wire logic tx_payload_ready,
  input wire logic tx_repeat,
  input wire logic tx_blocked,
  input wire logic features_on
);
  logic [4:0] cs_idle;
  logic [2:0] ev_age;
  ////////////////////////////////////////////////////////////////////////////
  // idle time since select rose; commits land a few cycles after the rise
  always_ff @(posedge clk) begin
    if (!nrst || !spi_cs_n) cs_idle <= 5'h00;
    else if (cs_idle != 5'h1f) cs_idle <= cs_idle + 5'h01;
  end
  // age of the last flag event, saturating so it never wraps
  always_ff @(posedge clk) begin
    if (!nrst) ev_age <= 3'h7;
    else if (ev_received || ev_sent || ev_retry_limit) ev_age <= 3'h0;
    else if (ev_age != 3'h7) ev_age <= ev_age + 3'h1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////////
  property p_irq_src;
    $fell(irq_n) |-> ev_age <= 3'h4;
  endproperty
  a_irq_src: assert property (p_irq_src)
    else $error("irq fell without a flag event");
  property p_irq_hold;
    !irq_n && cs_idle > 5'h0c |=> !irq_n;
  endproperty
  a_irq_hold: assert property (p_irq_hold)
    else $error("irq released without a write");
  property p_irq_clr;
    $rose(irq_n) |-> cs_idle < 5'h0c;
  endproperty
  a_irq_clr: assert property (p_irq_clr)
    else $error("irq rose away from a command end");
  property p_oe_on;
    $fell(spi_cs_n) |-> ##[1:6] spi_miso_oe;
  endproperty
  a_oe_on: assert property (p_oe_on)
    else $error("status not driven after select");
  property p_oe_off;
    cs_idle > 5'h06 |-> !spi_miso_oe;
  endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("serial out driven while deselected");
  property p_rep_hold;
    tx_repeat && cs_idle > 5'h08 |=> tx_repeat;
  endproperty
  a_rep_hold: assert property (p_rep_hold)
    else $error("repeat dropped without a command");
  property p_rdy_hold;
    tx_payload_ready && cs_idle > 5'h08 && !ev_tx_done
      && !$past(ev_tx_done) |=> tx_payload_ready;
  endproperty
  a_rdy_hold: assert property (p_rdy_hold)
    else $error("tx entry lost without a pop");
  property p_blk_role;
    !receiver_role && !$past(receiver_role) && !$past(receiver_role, 2)
      |-> !tx_blocked;
  endproperty
  a_blk_role: assert property (p_blk_role)
    else $error("tx blocked outside receiver role");
  property p_feat;
    cs_idle > 5'h08 |=> $stable(features_on);
  endproperty
  a_feat: assert property (p_feat)
    else $error("features toggled without a command");
  property p_ce;
    !ce |=> $stable(irq_n) && $stable(spi_miso_oe);
  endproperty
  a_ce: assert property (p_ce)
    else $error("outputs moved while frozen");
endmodule : rsc_spi_core_monitor
bind rsc_spi_core rsc_spi_core_monitor u_rsc_spi_core_monitor (.clk, .nrst,
  .ce, .spi_cs_n, .spi_miso_oe, .irq_n, .receiver_role, .ev_received,
  .ev_sent, .ev_retry_limit, .ev_tx_done, .tx_payload_ready, .tx_repeat,
  .tx_blocked, .features_on);

// >>> rsc_spi_core_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
  n_compared++; \
  if ((g) !== (e)) begin \
    n_errors++; \
    $display("[FAIL] %s exp %h got %h", nm, (e), (g)); \
  end \
end
module rsc_spi_core_tb
  import rsc_pkg::*;
;
  logic       clk, nrst, ce, standby, role, lost, rxv;
  logic       sck, cs_n, mosi, miso, oe, irq_n;
  logic       rdy, noack, rep, blk, feat;
  logic [4:0] ev;
  logic [2:0] pipe;
  logic [7:0] rxb;
  int         n_errors = 0;
  int         n_compared = 0;
  rsc_spi_core u_rsc_spi_core (.clk(clk), .nrst(nrst), .ce(ce),
    .spi_sck(sck), .spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso(miso),
    .spi_miso_oe(oe), .irq_n(irq_n), .standby(standby),
    .receiver_role(role), .ev_received(ev[2]), .ev_pipe(pipe),
    .ev_rx_byte(rxb), .ev_rx_byte_valid(rxv), .ev_rx_commit(ev[4]),
    .ev_sent(ev[1]), .ev_retry_limit(ev[0]), .ev_tx_done(ev[3]),
    .link_lost_all(lost), .tx_payload_ready(rdy), .tx_no_ack(noack),
    .tx_repeat(rep), .tx_blocked(blk), .features_on(feat));
  // a deselected serial out floats; the host sees z, never a stale bit
  rsc_spi_host u_rsc_spi_host (.clk(clk), .sck(sck), .cs_n(cs_n),
    .mosi(mosi), .miso(oe ? miso : 1'bz));
  ////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  function automatic logic [7:0] got(input int i);
    return u_rsc_spi_host.rx[i];
  endfunction : got
  task automatic sp(input logic [7:0] op, input int n, input logic [7:0] b);
    u_rsc_spi_host.tx[0] = op;
    for (int i = 1; i <= n; i++) u_rsc_spi_host.tx[i] = b + 8'(i - 1);
    u_rsc_spi_host.frame(n + 1);
  endtask : sp
  task automatic pulse(input logic [4:0] v);
    @(posedge clk) ev <= v;
    @(posedge clk) ev <= 5'h00;
    tick(4);
  endtask : pulse
  // three bytes a0..a2 into one rx entry, then the received flag
  task automatic push(input logic [2:0] p);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk) rxb <= 8'ha0 + 8'(i);
      rxv <= 1'b1;
      pipe <= p;
      @(posedge clk) rxv <= 1'b0;
    end
    pulse(5'h10);
    pulse(5'h04);
  endtask : push
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    @(posedge clk) ce <= 1'b0;
    tick(4);
    ce <= 1'b1;
    sp(CMD_RD_REG | REG_CONFIG, 1, 8'h00);
    `CHK("config", CONFIG_RST, got(1))
    sp(CMD_RD_REG | REG_FIFO_STATUS, 1, 8'h00);
    `CHK("fifo status", 8'h11, got(1))
    sp(CMD_WR_REG | 8'h0a, 5, 8'h10);
    sp(CMD_WR_REG | 8'h0a, 2, 8'h50);
    @(posedge clk) standby <= 1'b0;
    sp(CMD_WR_REG | 8'h0a, 1, 8'h99);
    @(posedge clk) standby <= 1'b1;
    sp(CMD_WR_REG | REG_TEST_LO, 1, 8'h5a);
    sp(CMD_RD_REG | REG_TEST_LO, 1, 8'h00);
    `CHK("test reg", 8'h00, got(1))
    sp(CMD_RD_REG | 8'h0a, 5, 8'h00);
    for (int i = 1; i <= 5; i++)
      `CHK("reg", (i < 3) ? 8'h4f + 8'(i) : 8'h0f + 8'(i), got(i))
  endtask : t_regs
  task automatic t_irq;
    logic [7:0] m;
    for (int i = 0; i < 3; i++) begin
      m = 8'h40 >> i;
      pulse(5'(4 >> i));
      `CHK("irq low", 1'b0, irq_n)
      sp(CMD_IDLE, 0, 8'h00);
      `CHK("status", m, got(0) & 8'hf1)
      sp(CMD_WR_REG | REG_STATUS, 1, m);
      `CHK("irq cleared", 1'b1, irq_n)
      sp(CMD_WR_REG | REG_CONFIG, 1, CONFIG_RST | m);
      pulse(5'(4 >> i));
      `CHK("irq masked", 1'b1, irq_n)
      sp(CMD_WR_REG | REG_STATUS, 1, m);
      sp(CMD_WR_REG | REG_CONFIG, 1, CONFIG_RST);
    end
  endtask : t_irq
  task automatic t_tx;
    sp(CMD_TX_WRITE, 1, 8'h01);
    sp(CMD_TX_WRITE, 32, 8'h02);
    sp(CMD_TX_WRITE, 1, 8'h03);
    sp(CMD_TX_WRITE, 1, 8'h04);
    `CHK("tx full", 8'h01, got(0) & 8'h01)
    sp(CMD_RD_REG | REG_FIFO_STATUS, 1, 8'h00);
    `CHK("fifo full", 8'h21, got(1))
    pulse(5'h01);
    `CHK("kept on retry", 1'b1, rdy)
    sp(CMD_WR_REG | REG_STATUS, 1, 8'h10);
    sp(CMD_REPEAT, 0, 8'h00);
    `CHK("repeat", 1'b1, rep)
    pulse(5'h08);
    sp(CMD_RD_REG | REG_FIFO_STATUS, 1, 8'h00);
    `CHK("repeat kept", 8'h61, got(1))
    sp(CMD_TX_FLUSH, 0, 8'h00);
    sp(CMD_RD_REG | REG_FIFO_STATUS, 1, 8'h00);
    `CHK("flushed", 8'h11, got(1))
    `CHK("repeat off", 1'b0, rep)
    sp(CMD_REPEAT, 0, 8'h00);
    sp(CMD_TX_WRITE, 1, 8'h05);
    `CHK("repeat off", 1'b0, rep)
    `CHK("ready", 1'b1, rdy)
    pulse(5'h08);
    `CHK("popped", 1'b0, rdy)
  endtask : t_tx
  task automatic t_rx;
    push(3'h2);
    sp(CMD_IDLE, 0, 8'h00);
    `CHK("pipe", 8'h44, got(0) & 8'h4e)
    sp(CMD_WR_REG | REG_STATUS, 1, 8'h40);
    sp(CMD_RX_WIDTH, 1, 8'h00);
    `CHK("locked width", 8'h00, got(1))
    sp(CMD_UNLOCK, 1, UNLOCK_KEY);
    `CHK("unlocked", 1'b1, feat)
    sp(CMD_RX_WIDTH, 1, 8'h00);
    `CHK("width", 8'h03, got(1))
    sp(CMD_RX_READ, 3, 8'h00);
    for (int i = 1; i <= 3; i++) `CHK("rx", 8'h9f + 8'(i), got(i))
    sp(CMD_RD_REG | REG_FIFO_STATUS, 1, 8'h00);
    `CHK("rx popped", 8'h11, got(1))
    sp(CMD_RX_READ, 1, 8'h00);
    `CHK("empty read", 8'h00, got(1))
    push(3'h1);
    sp(CMD_RX_FLUSH, 0, 8'h00);
    sp(CMD_RD_REG | REG_FIFO_STATUS, 1, 8'h00);
    `CHK("rx flushed", 8'h11, got(1))
    sp(CMD_WR_REG | REG_STATUS, 1, 8'h40);
  endtask : t_rx
  task automatic t_ack;
    @(posedge clk) role <= 1'b1;
    lost <= 1'b1;
    sp(CMD_ACK_WR_BASE | 8'h01, 2, 8'h30);
    `CHK("blocked", 1'b1, blk)
    sp(CMD_TX_FLUSH, 0, 8'h00);
    `CHK("unblocked", 1'b0, blk)
    sp(CMD_ACK_WR_BASE | 8'h06, 1, 8'h33);
    `CHK("bad pipe", 1'b0, rdy)
    @(posedge clk) role <= 1'b0;
    lost <= 1'b0;
    sp(CMD_NOACK_WR, 1, 8'h31);
    `CHK("no ack", 1'b1, noack)
    sp(CMD_TX_FLUSH, 0, 8'h00);
    `CHK("no ack flushed", 1'b0, noack)
    sp(CMD_UNLOCK, 1, UNLOCK_KEY);
    `CHK("locked", 1'b0, feat)
    sp(CMD_NOACK_WR, 1, 8'h32);
    `CHK("locked write", 1'b0, rdy)
    @(posedge clk) standby <= 1'b0;
    sp(CMD_UNLOCK, 1, UNLOCK_KEY);
    `CHK("unlock refused", 1'b0, feat)
    @(posedge clk) standby <= 1'b1;
  endtask : t_ack
  task automatic close_out;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // main sequence; writes need standby, so it stays up by default
  initial begin
    {nrst, role, lost, ev, pipe, rxb, rxv} = '0;
    ce = 1'b1;
    standby = 1'b1;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    tick(1);
    t_regs;
    t_irq;
    t_tx;
    t_rx;
    t_ack;
    close_out;
  end
  // the sequence needs well under half a millisecond
  initial begin
    #2000000;
    n_errors++;
    close_out;
  end
endmodule : rsc_spi_core_tb

// >>> rsc_spi_host.sv
`timescale 1ns/1ps
module rsc_spi_host (
  input  wire logic clk,
  output logic      sck,
  output logic      cs_n,
  output logic      mosi,
  input  wire logic miso
);
  logic [7:0] tx [0:32];
  logic [7:0] rx [0:32];
  // serial clock stands low between frames
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // one frame, command byte then data bytes, msb first; 200 ns bit time
  task automatic frame(input int n);
    @(posedge clk);
    #7 cs_n = 1'b0;
    #200;
    for (int i = 0; i < n; i++) begin
      for (int k = 7; k >= 0; k--) begin
        mosi = tx[i][k];
        #100 sck = 1'b1;
        rx[i][k] = miso;
        #100 sck = 1'b0;
      end
    end
    #100 cs_n = 1'b1;
    mosi = ~mosi;
    #200;
  endtask : frame
endmodule : rsc_spi_host
